/* File: rtl/upl_pkg.sv */
package upl_pkg;
    // ****************************************************************
    // bit positions inside the modem control register
    // ****************************************************************
    localparam int UPL_MCR_RTS_BIT = 1;
    localparam int UPL_MCR_LOOP_BIT = 4;
    localparam int UPL_MCR_INTDRV_BIT = 5;
    localparam int UPL_MCR_RING_BIT = 6;
    localparam logic [7:0] UPL_MCR_RESET = 8'h00;
    // ****************************************************************
    // register addresses (three address lines)
    // ****************************************************************
    localparam logic [2:0] UPL_ADDR_DATA = 3'h0;
    localparam logic [2:0] UPL_ADDR_IER = 3'h1;
    localparam logic [2:0] UPL_ADDR_MCR = 3'h4;
    localparam logic [2:0] UPL_ADDR_MSR = 3'h6;
    localparam logic [7:0] UPL_IER_RESET = 8'h00;
    localparam int UPL_IER_MSI_BIT = 3;
    localparam int UPL_IER_TXEN_BIT = 7;
    // ****************************************************************
    // serial timing: cycles per bit, buffer depth
    // ****************************************************************
    localparam logic [7:0] UPL_BIT_CYCLES = 8'h10;
    localparam int UPL_BUF_DEPTH = 2;
    localparam logic [3:0] UPL_FRAME_BITS = 4'h9;
    typedef enum logic [1:0] {UPL_SER_IDLE, UPL_SER_START, UPL_SER_DATA, UPL_SER_STOP} upl_ser_e;
endpackage

/* File: rtl/upl_if.sv */
`timescale 1ns/1ps
interface upl_if;
    logic bus_mode;
    logic read_strobe_n;
    logic write_strobe_n;
    logic master_reset;
    logic power_down_request;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic call_alert_input_n;
    logic rts_n;
    logic tx;
    logic tx_oe;
    logic rx;
    logic irq;
    logic irq_oe;
    modport device (input bus_mode, read_strobe_n, write_strobe_n, master_reset, power_down_request, addr, wdata,
        call_alert_input_n, rx, output rdata, rts_n, tx, tx_oe, irq, irq_oe);
    modport host (output bus_mode, read_strobe_n, write_strobe_n, master_reset, power_down_request, addr, wdata,
        call_alert_input_n, rx, input rdata, rts_n, tx, tx_oe, irq, irq_oe);
endinterface

/* File: rtl/upl_device.sv */
// Functional notes
// - mode high: read strobe active low
// - mode high: write strobe active low
// - mode low: direction line picks read/write
// - power request stops clocked work after its two-stage sync
// - stays low power while request high
// - release of request resets all registers
// - mode high: master reset active high
// - mode low: master reset active low
// - ring low means ring; rise interrupts
// - ring state readable in control bit 6
// - control bit 1 drives rts low
// - rts high after any reset
// - tx idles high, reset, disabled
// - far end holds rx high idle
// - loopback feeds tx into receiver
// - loopback disables external tx pin
// - control bit 5 selects irq drive
`timescale 1ns/1ps
module upl_device
    import upl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    upl_if.device LINK
);
    typedef struct packed {
        logic [1:0] mode_s;
        logic [1:0] rd_s;
        logic [1:0] wr_s;
        logic [1:0] rst_s;
        logic [1:0] pd_s;
        logic [1:0] ri_s;
        logic [1:0] rx_s;
        logic rd_prev;
        logic wr_prev;
        logic ri_prev;
        logic [7:0] modem_control_reg;
        logic [7:0] ier;
        logic [7:0] rdata;
        logic ri_delta;
        logic [UPL_BUF_DEPTH-1:0][7:0] tx_buf;
        logic [1:0] tx_cnt;
        upl_ser_e ser;
        logic [7:0] tx_shift;
        logic [3:0] bit_idx;
        logic [7:0] div;
        logic [7:0] rx_byte;
        logic [7:0] rx_shift;
        logic [7:0] rx_div;
        logic [3:0] rx_idx;
        logic rx_busy;
        logic tx_line;
        logic rts_n;
        logic tx;
        logic tx_oe;
        logic irq;
        logic irq_oe;
    } upl_dev_s;
    upl_dev_s s_q, s_d;
    logic mode, rd_act, wr_act, rst_act, pd, lb, ser_in;
    // ****************************************************************
    // combinational next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.mode_s = {s_q.mode_s[0], LINK.bus_mode};
        s_d.rd_s = {s_q.rd_s[0], LINK.read_strobe_n};
        s_d.wr_s = {s_q.wr_s[0], LINK.write_strobe_n};
        s_d.rst_s = {s_q.rst_s[0], LINK.master_reset};
        s_d.pd_s = {s_q.pd_s[0], LINK.power_down_request};
        s_d.ri_s = {s_q.ri_s[0], LINK.call_alert_input_n};
        s_d.rx_s = {s_q.rx_s[0], LINK.rx};
        mode = s_q.mode_s[1];
        pd = s_q.pd_s[1];
        // mode low: write line gives direction; with no chip select here the read line frames the access
        rd_act = mode ? !s_q.rd_s[1] : s_q.wr_s[1] && !s_q.rd_s[1];
        wr_act = mode ? !s_q.wr_s[1] : !s_q.wr_s[1] && !s_q.rd_s[1];
        rst_act = mode ? s_q.rst_s[1] : !s_q.rst_s[1];
        lb = s_q.modem_control_reg[UPL_MCR_LOOP_BIT];
        ser_in = lb ? s_q.tx_line : s_q.rx_s[1];
        s_d.rd_prev = rd_act;
        s_d.wr_prev = wr_act;
        s_d.ri_prev = s_q.ri_s[1];
        if (!pd) begin
            // ring rise is the interrupting event; set beats clear
            if (s_q.ri_s[1] && !s_q.ri_prev) begin
                s_d.ri_delta = 1'b1;
            end else if (rd_act && !s_q.rd_prev && LINK.addr == UPL_ADDR_MSR) begin
                s_d.ri_delta = 1'b0;
            end
            if (rd_act && !s_q.rd_prev) begin
                unique case (LINK.addr)
                    UPL_ADDR_DATA: s_d.rdata = s_q.rx_byte;
                    UPL_ADDR_IER: s_d.rdata = s_q.ier;
                    UPL_ADDR_MCR: begin
                        s_d.rdata = s_q.modem_control_reg;
                        s_d.rdata[UPL_MCR_RING_BIT] = !s_q.ri_s[1];
                    end
                    UPL_ADDR_MSR: s_d.rdata = {1'b0, !s_q.ri_s[1], 5'h00, s_q.ri_delta};
                    default: s_d.rdata = 8'h00;
                endcase
            end
            s_d.tx_cnt = s_q.tx_cnt;
            if (wr_act && !s_q.wr_prev) begin
                if (LINK.addr == UPL_ADDR_MCR) begin
                    s_d.modem_control_reg = LINK.wdata;
                end
                if (LINK.addr == UPL_ADDR_IER) begin
                    s_d.ier = LINK.wdata;
                end
                // two-entry buffer; a full buffer drops the write
                if (LINK.addr == UPL_ADDR_DATA && s_q.tx_cnt < 2'(UPL_BUF_DEPTH)) begin
                    s_d.tx_buf[s_q.tx_cnt[0]] = LINK.wdata;
                    s_d.tx_cnt = s_q.tx_cnt + 2'd1;
                end
            end
            // transmitter, enabled by ier bit 7
            s_d.div = (s_q.div == 8'h00) ? UPL_BIT_CYCLES - 8'h01 : s_q.div - 8'h01;
            if (s_q.div == 8'h00) begin
                unique case (s_q.ser)
                    UPL_SER_IDLE: begin
                        s_d.tx_line = 1'b1;
                        if (s_d.tx_cnt != 2'd0 && s_q.ier[UPL_IER_TXEN_BIT]) begin
                            s_d.tx_shift = s_d.tx_buf[0];
                            s_d.tx_buf[0] = s_d.tx_buf[1];
                            s_d.tx_cnt = s_d.tx_cnt - 2'd1;
                            s_d.ser = UPL_SER_START;
                        end
                    end
                    UPL_SER_START: begin
                        s_d.tx_line = 1'b0;
                        s_d.bit_idx = 4'h0;
                        s_d.ser = UPL_SER_DATA;
                    end
                    UPL_SER_DATA: begin
                        s_d.tx_line = s_q.tx_shift[0];
                        s_d.tx_shift = {1'b1, s_q.tx_shift[7:1]};
                        s_d.bit_idx = s_q.bit_idx + 4'h1;
                        if (s_q.bit_idx == UPL_FRAME_BITS - 4'h2) begin
                            s_d.ser = UPL_SER_STOP;
                        end
                    end
                    UPL_SER_STOP: begin
                        s_d.tx_line = 1'b1;
                        s_d.ser = UPL_SER_IDLE;
                    end
                endcase
            end
            // receiver: sample mid-bit after falling start edge
            if (!s_q.rx_busy) begin
                if (!ser_in) begin
                    s_d.rx_busy = 1'b1;
                    s_d.rx_div = UPL_BIT_CYCLES + (UPL_BIT_CYCLES >> 1);
                    s_d.rx_idx = 4'h0;
                end
            end else if (s_q.rx_div == 8'h00) begin
                s_d.rx_div = UPL_BIT_CYCLES - 8'h01;
                s_d.rx_idx = s_q.rx_idx + 4'h1;
                if (s_q.rx_idx == UPL_FRAME_BITS - 4'h1) begin
                    s_d.rx_busy = 1'b0;
                    s_d.rx_byte = s_q.rx_shift;
                end else begin
                    s_d.rx_shift = {ser_in, s_q.rx_shift[7:1]};
                end
            end else begin
                s_d.rx_div = s_q.rx_div - 8'h01;
            end
        end
        // outputs registered from state
        s_d.rts_n = !s_d.modem_control_reg[UPL_MCR_RTS_BIT];
        s_d.tx = lb ? 1'b1 : s_d.tx_line;
        s_d.tx_oe = !lb;
        s_d.irq = s_d.ri_delta && s_d.ier[UPL_IER_MSI_BIT];
        // drive either always, or only while asserted (open source)
        s_d.irq_oe = s_d.modem_control_reg[UPL_MCR_INTDRV_BIT] || s_d.irq;
        // release of the power request acts as a full reset
        if (SYS_RST || rst_act || (s_q.pd_s[1] && !s_q.pd_s[0])) begin
            s_d.modem_control_reg = UPL_MCR_RESET;
            s_d.ier = UPL_IER_RESET;
            s_d.ri_delta = 1'b0;
            s_d.tx_cnt = 2'd0;
            s_d.ser = UPL_SER_IDLE;
            s_d.tx_line = 1'b1;
            s_d.rx_busy = 1'b0;
            s_d.rdata = 8'h00;
            s_d.rx_byte = 8'h00;
            s_d.rts_n = 1'b1;
            s_d.tx = 1'b1;
            s_d.tx_oe = 1'b1;
            s_d.irq = 1'b0;
            s_d.irq_oe = 1'b0;
        end
    end
    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            s_q <= '0;
            s_q.mode_s <= 2'b11;
            s_q.rd_s <= 2'b11;
            s_q.wr_s <= 2'b11;
            s_q.ri_s <= 2'b11;
            s_q.rx_s <= 2'b11;
            s_q.ri_prev <= 1'b1;
            s_q.ser <= UPL_SER_IDLE;
            s_q.tx_line <= 1'b1;
            s_q.rts_n <= 1'b1;
            s_q.tx <= 1'b1;
            s_q.tx_oe <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
    assign LINK.rdata = s_q.rdata;
    assign LINK.rts_n = s_q.rts_n;
    assign LINK.tx = s_q.tx;
    assign LINK.tx_oe = s_q.tx_oe;
    assign LINK.irq = s_q.irq;
    assign LINK.irq_oe = s_q.irq_oe;
endmodule

/* File: rtl/upl_host.sv */
`timescale 1ns/1ps
module upl_host
    import upl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    upl_if.host LINK,
    input wire logic BUS_MODE,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [2:0] REQ_ADDR,
    input wire logic [7:0] REQ_WDATA,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [7:0] RSP_DATA,
    input wire logic MODEM_RESET,
    input wire logic POWER_DOWN,
    input wire logic RING_N,
    input wire logic SER_RX
);
    typedef struct packed {
        logic [3:0] phase;
        logic mode;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic rd_n;
        logic wr_n;
        logic rst;
        logic pd;
        logic ri_n;
        logic rx;
        logic ready;
        logic rsp_valid;
        logic [7:0] rsp;
    } upl_host_s;
    upl_host_s h_q, h_d;
    // ****************************************************************
    // access sequencer: strobe held 7 cycles to clear the sync chain
    // ****************************************************************
    always_comb begin
        h_d = h_q;
        h_d.rsp_valid = 1'b0;
        h_d.pd = POWER_DOWN;
        // registered beside the reset line so the pair never disagrees at the far end
        h_d.mode = BUS_MODE;
        h_d.ri_n = RING_N;
        h_d.rst = BUS_MODE ? MODEM_RESET : !MODEM_RESET;
        h_d.rx = SER_RX;
        if (h_q.phase == 4'h0) begin
            h_d.rd_n = 1'b1;
            h_d.wr_n = BUS_MODE ? 1'b1 : 1'b1;
            h_d.ready = 1'b1;
            if (REQ_VALID && h_q.ready) begin
                h_d.ready = 1'b0;
                h_d.wr = REQ_WRITE;
                h_d.addr = REQ_ADDR;
                h_d.wdata = REQ_WDATA;
                h_d.phase = 4'h1;
            end
        end else if (h_q.phase < 4'h8) begin
            h_d.phase = h_q.phase + 4'h1;
            if (BUS_MODE) begin
                h_d.rd_n = h_q.wr;
                h_d.wr_n = !h_q.wr;
            end else begin
                // read line frames the access, write line gives direction
                h_d.rd_n = 1'b0;
                h_d.wr_n = !h_q.wr;
            end
        end else if (h_q.phase < 4'hC) begin
            h_d.rd_n = 1'b1;
            h_d.wr_n = 1'b1;
            h_d.phase = h_q.phase + 4'h1;
        end else begin
            h_d.phase = 4'h0;
            h_d.rsp_valid = !h_q.wr;
            h_d.rsp = LINK.rdata;
            h_d.ready = 1'b1;
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            h_q <= '0;
            h_q.rd_n <= 1'b1;
            h_q.wr_n <= 1'b1;
            h_q.ri_n <= 1'b1;
            h_q.rx <= 1'b1;
            h_q.mode <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end
    assign LINK.bus_mode = h_q.mode;
    assign LINK.read_strobe_n = h_q.rd_n;
    assign LINK.write_strobe_n = h_q.wr_n;
    assign LINK.master_reset = h_q.rst;
    assign LINK.power_down_request = h_q.pd;
    assign LINK.addr = h_q.addr;
    assign LINK.wdata = h_q.wdata;
    assign LINK.call_alert_input_n = h_q.ri_n;
    assign LINK.rx = h_q.rx;
    assign REQ_READY = h_q.ready;
    assign RSP_VALID = h_q.rsp_valid;
    assign RSP_DATA = h_q.rsp;
endmodule

/* File: verif/upl_assertions.sv */
`timescale 1ns/1ps
// ****************************************************
// link checks between the host end and the device end
// ****************************************************
module upl_assertions (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic bus_mode,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic master_reset,
    input wire logic power_down_request,
    input wire logic [7:0] rdata,
    input wire logic call_alert_input_n,
    input wire logic rts_n,
    input wire logic tx,
    input wire logic tx_oe,
    input wire logic irq,
    input wire logic irq_oe
);
    logic wr_act;
    logic rd_act;
    logic [3:0] wr_age_q;
    logic [3:0] rd_age_q;
    logic [3:0] ring_age_q;
    // strobe decode per bus style; direction style is qualified by read_strobe_n
    assign wr_act = bus_mode ? !write_strobe_n : (!read_strobe_n && !write_strobe_n);
    assign rd_act = bus_mode ? !read_strobe_n : (!read_strobe_n && write_strobe_n);
    // ages saturate so an old cause never looks fresh again
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            wr_age_q <= 4'hF;
            rd_age_q <= 4'hF;
            ring_age_q <= 4'hF;
        end else begin
            wr_age_q <= wr_act ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hF};
            rd_age_q <= rd_act ? 4'h0 : rd_age_q + {3'h0, rd_age_q != 4'hF};
            ring_age_q <= $rose(call_alert_input_n) ? 4'h0 : ring_age_q + {3'h0, ring_age_q != 4'hF};
        end
    end
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);
    // outputs every reset must leave at rest
    sequence s_rest;
        rts_n && tx && tx_oe;
    endsequence
    sequence s_mode1_rst;
        (bus_mode && master_reset) [*6];
    endsequence
    sequence s_mode0_rst;
        (!bus_mode && !master_reset) [*6];
    endsequence
    property p_post_reset;
        $fell(SYS_RST) |-> s_rest;
    endproperty
    property p_mode1_rst;
        s_mode1_rst |-> s_rest;
    endproperty
    property p_mode0_rst;
        s_mode0_rst |-> s_rest;
    endproperty
    property p_power_hold;
        power_down_request [*5] |-> $stable(rts_n) && $stable(tx_oe) && $stable(rdata);
    endproperty
    property p_power_wake;
        $fell(power_down_request) |-> ##[1:8] s_rest;
    endproperty
    property p_rts_cause;
        $fell(rts_n) |-> wr_age_q < 4'h8;
    endproperty
    property p_loop_cause;
        $fell(tx_oe) |-> wr_age_q < 4'h8;
    endproperty
    property p_ring_irq;
        $rose(irq) |-> ring_age_q < 4'hA;
    endproperty
    property p_irq_drive;
        irq [*2] |-> irq_oe;
    endproperty
    property p_rdata_cause;
        $changed(rdata) |-> rd_age_q < 4'h8 || rdata == 8'h00;
    endproperty
    a_post_reset: assert property (p_post_reset) else $error("outputs not at rest after reset");
    a_mode1_rst: assert property (p_mode1_rst) else $error("high reset ignored");
    a_mode0_rst: assert property (p_mode0_rst) else $error("low reset ignored");
    a_power_hold: assert property (p_power_hold) else $error("state moved in low power");
    a_power_wake: assert property (p_power_wake) else $error("no reset on wake");
    a_rts_cause: assert property (p_rts_cause) else $error("rts asserted without write");
    a_loop_cause: assert property (p_loop_cause) else $error("tx pin off without write");
    a_ring_irq: assert property (p_ring_irq) else $error("irq without ring rise");
    a_irq_drive: assert property (p_irq_drive) else $error("irq high but not driven");
    a_rdata_cause: assert property (p_rdata_cause) else $error("read data moved without read");
endmodule

/* File: verif/upl_tb_top.sv */
`timescale 1ns/1ps
// ****************************************************
// both ends joined; bench drives the host user side
// ****************************************************
module upl_tb_top;
    import upl_pkg::*;
    logic core_clk, sys_rst, bus_mode, req_valid, req_write, req_ready, rsp_valid;
    logic modem_reset, power_down, ring_n, ser_rx;
    logic [2:0] req_addr;
    logic [7:0] req_wdata, rsp_data, q;
    int checks = 0;
    int n_mismatch = 0;
    upl_if upl_if_i ();
    upl_device upl_device_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK(upl_if_i));
    upl_host upl_host_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK(upl_if_i), .BUS_MODE(bus_mode),
        .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .MODEM_RESET(modem_reset),
        .POWER_DOWN(power_down), .RING_N(ring_n), .SER_RX(ser_rx));
    upl_assertions upl_assertions_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .bus_mode(upl_if_i.bus_mode),
        .read_strobe_n(upl_if_i.read_strobe_n), .write_strobe_n(upl_if_i.write_strobe_n),
        .master_reset(upl_if_i.master_reset), .power_down_request(upl_if_i.power_down_request),
        .rdata(upl_if_i.rdata), .call_alert_input_n(upl_if_i.call_alert_input_n), .rts_n(upl_if_i.rts_n),
        .tx(upl_if_i.tx), .tx_oe(upl_if_i.tx_oe), .irq(upl_if_i.irq), .irq_oe(upl_if_i.irq_oe));
    // 100 MHz
    always #5 core_clk = ~core_clk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    // one access; request held until ready is seen high before an edge, answer waited with a bound
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        // ready stands between edges, so the next rising edge takes the request
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        // writes give no answer pulse; they end when ready returns
        while (!(w ? req_ready === 1'b1 : rsp_valid === 1'b1) && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        q = rsp_data;
        if (n >= 40) begin
            n_mismatch++;
            summarize();
        end
    endtask
    // request-to-send and read back, in both bus styles
    task automatic t_rts();
        for (int m = 0; m < 2; m++) begin
            bus_mode = m[0];
            cyc(8);
            chk({7'h0, upl_if_i.master_reset}, {7'h0, ~m[0]});
            acc(1'b1, UPL_ADDR_MCR, 8'h02);
            cyc(2);
            chk({7'h0, upl_if_i.rts_n}, 8'h00);
            acc(1'b0, UPL_ADDR_MCR, 8'h00);
            chk(q, 8'h02);
            acc(1'b1, UPL_ADDR_MCR, 8'h00);
            cyc(2);
            chk({7'h0, upl_if_i.rts_n}, 8'h01);
        end
    endtask
    // master reset polarity follows the bus style
    task automatic t_mreset();
        for (int m = 0; m < 2; m++) begin
            bus_mode = m[0];
            cyc(8);
            acc(1'b1, UPL_ADDR_MCR, 8'h02);
            modem_reset = 1'b1;
            cyc(10);
            chk({7'h0, upl_if_i.master_reset}, {7'h0, m[0]});
            chk({7'h0, upl_if_i.rts_n}, 8'h01);
            modem_reset = 1'b0;
            cyc(8);
        end
    endtask
    // writes ignored while asleep, full reset on wake
    task automatic t_power();
        acc(1'b1, UPL_ADDR_MCR, 8'h02);
        power_down = 1'b1;
        cyc(6);
        acc(1'b1, UPL_ADDR_MCR, 8'h00);
        chk({7'h0, upl_if_i.rts_n}, 8'h00);
        power_down = 1'b0;
        cyc(10);
        chk({7'h0, upl_if_i.rts_n}, 8'h01);
        acc(1'b0, UPL_ADDR_MCR, 8'h00);
        chk(q, 8'h00);
    endtask
    // ring state, interrupt on rise, drive select, masking
    task automatic t_ring();
        acc(1'b1, UPL_ADDR_IER, 8'h08);
        ring_n = 1'b0;
        cyc(8);
        acc(1'b0, UPL_ADDR_MCR, 8'h00);
        chk(q, 8'h40);
        ring_n = 1'b1;
        cyc(8);
        chk({7'h0, upl_if_i.irq}, 8'h01);
        acc(1'b0, UPL_ADDR_MSR, 8'h00);
        chk(q, 8'h01);
        cyc(4);
        chk({6'h0, upl_if_i.irq, upl_if_i.irq_oe}, 8'h00);
        acc(1'b1, UPL_ADDR_MCR, 8'h20);
        cyc(2);
        chk({7'h0, upl_if_i.irq_oe}, 8'h01);
        acc(1'b1, UPL_ADDR_IER, 8'h00);
        ring_n = 1'b0;
        cyc(8);
        ring_n = 1'b1;
        cyc(8);
        chk({7'h0, upl_if_i.irq}, 8'h00);
        acc(1'b1, UPL_ADDR_MCR, 8'h00);
    endtask
    // loopback: pin off, external line low yet the byte comes back
    task automatic t_loop();
        acc(1'b1, UPL_ADDR_IER, 8'h80);
        acc(1'b1, UPL_ADDR_MCR, 8'h10);
        ser_rx = 1'b0;
        cyc(2);
        chk({6'h0, upl_if_i.tx_oe, upl_if_i.rx}, 8'h00);
        acc(1'b1, UPL_ADDR_DATA, 8'hA5);
        // mid-frame the pin must stay parked high and undriven
        cyc(60);
        chk({6'h0, upl_if_i.tx_oe, upl_if_i.tx}, 8'h01);
        cyc(190);
        acc(1'b0, UPL_ADDR_DATA, 8'h00);
        chk(q, 8'hA5);
        ser_rx = 1'b1;
        acc(1'b1, UPL_ADDR_MCR, 8'h00);
        cyc(2);
        chk({6'h0, upl_if_i.tx_oe, upl_if_i.tx}, 8'h03);
    endtask
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        bus_mode = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 3'h0;
        req_wdata = 8'h00;
        modem_reset = 1'b0;
        power_down = 1'b0;
        ring_n = 1'b1;
        ser_rx = 1'b1;
        cyc(10);
        sys_rst = 1'b0;
        cyc(4);
        chk({5'h0, upl_if_i.rts_n, upl_if_i.tx, upl_if_i.tx_oe}, 8'h07);
        t_rts();
        t_mreset();
        t_power();
        t_ring();
        t_loop();
        summarize();
    end
endmodule
